// *** design/csj_consts.svh ***
// constants for the compression split/join path
// Behaviour
// R1: each engine takes one pixel per clock
// R2: both engines in parallel give two pixels
// R3: splitter halves frame, engines use own sets
// R4: software sets slice and picture width per branch
// R5: front half upper mux, back half lower
// R6: joined stream only on upper mux
// R7: bypass passes pixels; psr2 changes engine source
// R8: odd slice receiver uses compress-only mode
// R9: uncompressed segmented or dual-link panels use split
// R10: compressed segmented or dual-link use split-compress
// R11: even slices use joiner, never with glass
// R12: independent ports: left first, right second port
// R13: dual link: split, no joiner, one pipe
// R14: single port: joined output on first only
// R15: picture height whole multiple of slice height
// R16: single branch embedded port uses left branch
// R17: settings written before vertical blank, applied there
// R18: pixel clock below ppc times core times pipes
// R19: output bpp below lanes link clock eight
// R20: big joiner bpp limit uses 24 bits
// R21: joiner buffer 7680 bytes per pipe
// R22: forward error correction scales pixel clock
`ifndef CSJ_CONSTS_SVH
`define CSJ_CONSTS_SVH
`define CSJ_PIX_W 30
`define CSJ_DROP_W 5
`define CSJ_WID_W 14
`define CSJ_BUF_DEPTH 2
`define CSJ_RAM_BYTES_PIPE 7680
`define CSJ_RAM_BYTES_JOINED 15360
`define CSJ_LINK_BITS 8
`define CSJ_BIGJ_BITS 24
`define CSJ_FEC_NUM 1000000
`define CSJ_FEC_DEN 972261
`endif

// *** design/csj_pkg.sv ***
// types shared by both ends of the compression split/join path
package csj_pkg;
`include "csj_consts.svh"
typedef logic [`CSJ_PIX_W-1:0] csj_pix_t;
typedef struct packed {
    logic [`CSJ_DROP_W-1:0] drop;
    logic [`CSJ_WID_W-1:0] slice_w;
    logic [`CSJ_WID_W-1:0] pic_w;
} csj_pps_t;
typedef struct packed {
    logic split;
    logic comp;
    logic joiner;
    logic psr2;
    csj_pps_t left;
    csj_pps_t right;
} csj_cfg_t;
typedef enum logic [4:0] {
    CSJ_BYPASS = 5'h01, CSJ_COMP = 5'h02, CSJ_SPLIT = 5'h04, CSJ_SPLITCOMP = 5'h08, CSJ_JOIN = 5'h10
} csj_mode_t;
typedef enum logic [7:0] {
    CSJ_UC_PLAIN = 8'h01, CSJ_UC_ODD = 8'h02, CSJ_UC_EVEN = 8'h04, CSJ_UC_SEG_RAW = 8'h08,
    CSJ_UC_SEG_DSC = 8'h10, CSJ_UC_DUAL_RAW = 8'h20, CSJ_UC_DUAL_DSC = 8'h40, CSJ_UC_INDEP = 8'h80
} csj_use_t;
// illegal switch combinations fall back to bypass
function automatic csj_mode_t csj_mode_of(input csj_cfg_t c);
    case ({c.split, c.comp, c.joiner})
        3'b010: return CSJ_COMP;
        3'b100: return CSJ_SPLIT;
        3'b110: return CSJ_SPLITCOMP;
        3'b111: return CSJ_JOIN;
        default: return CSJ_BYPASS;
    endcase
endfunction
// stand-in for the coder: keeps the top bits of the pixel
function automatic csj_pix_t csj_compress(input csj_pix_t p, input logic [`CSJ_DROP_W-1:0] drop);
    return p >> drop;
endfunction
endpackage

// *** design/csj_if.sv ***
// link between the pipe/port side and the split/join datapath
`timescale 1ns/1ps
`default_nettype none
`include "csj_consts.svh"
interface csj_if (input wire logic clk, input wire logic rstn);
    import csj_pkg::*;
    csj_cfg_t cfg;
    logic vblank;
    logic in_valid;
    logic in_ready;
    csj_pix_t in_a;
    csj_pix_t in_b;
    csj_pix_t in_alt;
    logic in_b_en;
    logic in_eol;
    logic up_valid;
    logic up_ready;
    logic [2*`CSJ_PIX_W-1:0] up_data;
    logic up_two;
    logic lo_valid;
    logic lo_ready;
    csj_pix_t lo_data;
    modport dev (input cfg, vblank, in_valid, in_a, in_b, in_alt, in_b_en, in_eol, up_ready, lo_ready,
        output in_ready, up_valid, up_data, up_two, lo_valid, lo_data);
    modport host (output cfg, vblank, in_valid, in_a, in_b, in_alt, in_b_en, in_eol, up_ready, lo_ready,
        input in_ready, up_valid, up_data, up_two, lo_valid, lo_data);
endinterface
`default_nettype wire

// *** design/csj_path.sv ***
// datapath end: splitter, two engines, joiner and output buffers
`timescale 1ns/1ps
`default_nettype none
`include "csj_consts.svh"
module csj_fifo #(parameter int W = 8, parameter int D = `CSJ_BUF_DEPTH) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    wire push = ce & in_valid & in_ready;
    wire pop = ce & out_valid & out_ready;
    wire [AW-1:0] wp_inc = (wp == AW'(D - 1)) ? '0 : wp + 1'b1;
    wire [AW-1:0] rp_inc = (rp == AW'(D - 1)) ? '0 : rp + 1'b1;
    assign in_ready = (cnt != (AW + 1)'(D));
    assign out_valid = (cnt != '0);
    assign out_data = mem[rp];
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (push) wp <= wp_inc;
            if (pop) rp <= rp_inc;
            if (push && !pop) cnt <= cnt + 1'b1;
            else if (pop && !push) cnt <= cnt - 1'b1;
        end
    end
endmodule

module csj_path import csj_pkg::*; (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    csj_if.dev bus,
    output csj_mode_t mode,
    output logic ram_over
);
    localparam int PW = `CSJ_PIX_W;
    localparam logic [31:0] RAM_BITS = 32'(`CSJ_RAM_BYTES_PIPE * 8);
    csj_cfg_t act;
    logic [31:0] line_bits;
    wire csj_mode_t m = csj_mode_of(act);
    wire comp_on = (m == CSJ_COMP) | (m == CSJ_SPLITCOMP) | (m == CSJ_JOIN);
    wire split_on = (m == CSJ_SPLIT) | (m == CSJ_SPLITCOMP) | (m == CSJ_JOIN);
    wire join_on = (m == CSJ_JOIN);
    // lane b is the back half when split, else in compress mode a second pipe when in_b_en
    wire b_used = split_on | (bus.in_b_en & (m == CSJ_COMP)); // R12
    wire lo_need = b_used & ~join_on; // R6
    wire csj_pix_t src_a = act.psr2 ? bus.in_alt : bus.in_a; // R7
    wire csj_pix_t left_w = comp_on ? csj_compress(src_a, act.left.drop) : src_a; // R1 R3
    wire csj_pix_t right_w = comp_on ? csj_compress(bus.in_b, act.right.drop) : bus.in_b; // R2 R3
    wire up_rdy;
    wire lo_rdy;
    wire take = ce & bus.in_valid & bus.in_ready;
    // one beat carries both halves, so a stalled lower port holds the upper too
    assign bus.in_ready = up_rdy & (lo_rdy | ~lo_need);
    wire [2*PW:0] up_word = join_on ? {1'b1, right_w, left_w} : {1'b0, {PW{1'b0}}, left_w}; // R5 R6
    wire [PW-1:0] beat_bits = PW'(2 * PW) - PW'(act.left.drop) - PW'(act.right.drop);
    wire [31:0] sum_bits = line_bits + 32'(beat_bits);
    assign mode = m;
    csj_fifo #(.W(2 * PW + 1), .D(`CSJ_BUF_DEPTH)) u_up (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .in_valid(take),
        .in_ready(up_rdy),
        .in_data(up_word),
        .out_valid(bus.up_valid),
        .out_ready(bus.up_ready),
        .out_data({bus.up_two, bus.up_data})
    );
    csj_fifo #(.W(PW), .D(`CSJ_BUF_DEPTH)) u_lo (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .in_valid(take & lo_need),
        .in_ready(lo_rdy),
        .in_data(right_w),
        .out_valid(bus.lo_valid),
        .out_ready(bus.lo_ready),
        .out_data(bus.lo_data)
    );
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            act <= '0;
        end else if (ce && bus.vblank) begin
            act <= bus.cfg; // R17
        end
    end
    // joiner buffer tally: a line that does not fit flags until the next blank
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_bits <= '0;
            ram_over <= 1'b0;
        end else if (ce) begin
            if (take && join_on) line_bits <= bus.in_eol ? '0 : sum_bits;
            if (take && join_on && sum_bits > RAM_BITS) ram_over <= 1'b1; // R21
            else if (bus.vblank) ram_over <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** design/csj_src.sv ***
// pipe and port end: chooses the mode, checks limits, feeds and drains the path
`timescale 1ns/1ps
`default_nettype none
`include "csj_consts.svh"
module csj_src import csj_pkg::*; (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    csj_if.host bus,
    input wire logic prog,
    input wire csj_use_t use_case,
    input wire logic [3:0] slices,
    input wire logic [`CSJ_WID_W-1:0] active_line_width,
    input wire logic [12:0] frame_h,
    input wire logic [12:0] slice_h,
    input wire logic [5:0] bpp_req,
    input wire logic psr2,
    input wire logic [31:0] pclk_khz,
    input wire logic [31:0] core_clk_khz,
    input wire logic [31:0] port_link_clock_khz,
    input wire logic [2:0] lanes,
    input wire logic fec_en,
    input wire logic big_joiner,
    input wire logic frame_vblank,
    input wire logic px_valid,
    output logic px_ready,
    input wire csj_pix_t px_a,
    input wire csj_pix_t px_b,
    input wire csj_pix_t px_alt,
    input wire logic px_b_en,
    input wire logic px_eol,
    output logic first_port_valid,
    input wire logic first_port_ready,
    output logic [2*`CSJ_PIX_W-1:0] first_port_data,
    output logic first_port_two,
    output logic second_port_valid,
    input wire logic second_port_ready,
    output csj_pix_t second_port_data,
    output logic cfg_err,
    output logic [7:0] max_bpp
);
    localparam int PW = `CSJ_PIX_W;

    function automatic logic [63:0] min64(input logic [63:0] a, input logic [63:0] b);
        return (a < b) ? a : b;
    endfunction

    csj_cfg_t cfg;
    logic vblank_q;

    // mode choice from the use case
    logic n_split;
    logic n_comp;
    logic n_join;
    logic bad_use;
    always_comb begin
        n_split = 1'b0;
        n_comp = 1'b0;
        n_join = 1'b0;
        bad_use = 1'b0;
        unique case (use_case)
            CSJ_UC_PLAIN: begin
            end
            CSJ_UC_ODD: begin
                n_comp = 1'b1; // R8 R16
            end
            CSJ_UC_EVEN: begin
                n_split = 1'b1; // R11
                n_comp = 1'b1;
                n_join = 1'b1;
            end
            CSJ_UC_SEG_RAW, CSJ_UC_DUAL_RAW: begin
                n_split = 1'b1; // R9 R13
            end
            CSJ_UC_SEG_DSC, CSJ_UC_DUAL_DSC: begin
                n_split = 1'b1; // R10 R13
                n_comp = 1'b1;
            end
            CSJ_UC_INDEP: begin
                n_comp = 1'b1; // R12
            end
            default: begin
                bad_use = 1'b1;
            end
        endcase
    end

    // branch geometry
    wire [1:0] branches = n_split ? 2'd2 : 2'd1;
    wire [`CSJ_WID_W-1:0] n_slice_w = (slices == '0) ? '0 :
        `CSJ_WID_W'(active_line_width / `CSJ_WID_W'(slices)); // R4
    wire [`CSJ_WID_W-1:0] n_pic_w = `CSJ_WID_W'(active_line_width / `CSJ_WID_W'(branches)); // R4
    wire bad_slices = (slices == '0) || ((slices % 4'(branches)) != '0);
    wire bad_height = (slice_h == '0) || ((frame_h % slice_h) != '0); // R15

    // bandwidth limits: clocks in kHz, limits in bits per pixel
    wire [63:0] pclk_eff = fec_en ?
        (64'(pclk_khz) * 64'(`CSJ_FEC_NUM)) / 64'(`CSJ_FEC_DEN) : 64'(pclk_khz); // R22
    wire [63:0] ppc = n_split ? 64'd2 : 64'd1;
    wire [63:0] pipes = big_joiner ? 64'd2 : 64'd1;
    wire [63:0] pipe_cap = ppc * 64'(core_clk_khz) * pipes;
    wire bad_pipe = (pclk_eff == '0) || !(pclk_eff < pipe_cap); // R18
    wire [63:0] link_num = 64'(lanes) * 64'(port_link_clock_khz) * 64'(`CSJ_LINK_BITS);
    // strictly below: largest whole value with bpp * pclk < link_num
    wire [63:0] link_lim = (pclk_eff == '0 || link_num == '0) ? '0 :
        (link_num - 64'd1) / pclk_eff; // R19
    wire [63:0] bigj_lim = (pclk_eff == '0) ? '0 :
        (ppc * 64'(core_clk_khz) * 64'(`CSJ_BIGJ_BITS)) / pclk_eff; // R20
    wire [63:0] ram_bits = big_joiner ? 64'(`CSJ_RAM_BYTES_JOINED * 8) : 64'(`CSJ_RAM_BYTES_PIPE * 8);
    wire [63:0] ram_lim = (active_line_width == '0) ? '0 :
        ram_bits / 64'(active_line_width); // R21
    wire [63:0] lim_a = min64(link_lim, ram_lim);
    wire [63:0] lim_all = big_joiner ? min64(lim_a, bigj_lim) : lim_a; // R20
    wire [7:0] n_max = (lim_all > 64'd255) ? 8'hFF : lim_all[7:0];
    wire bad_bpp = n_comp & ((bpp_req == '0) || (6'(PW) < bpp_req) || (8'(bpp_req) > n_max));
    wire [`CSJ_DROP_W-1:0] n_drop = n_comp ? `CSJ_DROP_W'(6'(PW) - bpp_req) : '0;
    wire n_err = bad_use | bad_height | bad_pipe | bad_bpp | (n_comp & bad_slices);

    csj_cfg_t next_cfg;
    always_comb begin
        next_cfg = '0;
        next_cfg.split = n_split;
        next_cfg.comp = n_comp;
        next_cfg.joiner = n_join;
        next_cfg.psr2 = psr2;
        next_cfg.left.drop = n_drop;
        next_cfg.left.slice_w = n_slice_w;
        next_cfg.left.pic_w = n_pic_w;
        next_cfg.right.drop = n_drop;
        next_cfg.right.slice_w = n_slice_w;
        next_cfg.right.pic_w = n_pic_w;
    end

    // settings change only on a program request and take effect at the next blank
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg <= '0;
            cfg_err <= 1'b0;
            max_bpp <= '0;
            vblank_q <= 1'b0;
        end else if (ce) begin
            if (prog) begin
                cfg <= next_cfg; // R17
                cfg_err <= n_err;
                max_bpp <= n_max;
            end
            vblank_q <= frame_vblank & ~prog; // R17
        end
    end
    assign bus.cfg = cfg;
    assign bus.vblank = vblank_q;

    // pixel feed: lane b is a second pipe only for independent ports
    wire indep = (csj_mode_of(cfg) == CSJ_COMP) & (use_case == CSJ_UC_INDEP);
    assign bus.in_valid = px_valid;
    assign px_ready = bus.in_ready;
    assign bus.in_a = px_a;
    assign bus.in_b = px_b;
    assign bus.in_alt = px_alt;
    assign bus.in_b_en = px_b_en & indep; // R12
    assign bus.in_eol = px_eol;

    // port side: upper mux feeds the first port, lower the second
    wire single_port = (csj_mode_of(cfg) == CSJ_JOIN);
    assign bus.up_ready = ~first_port_valid | first_port_ready;
    // the second port is idle in single port mode; lower mux never fills then
    assign bus.lo_ready = ~second_port_valid | second_port_ready | single_port; // R14
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            first_port_valid <= 1'b0;
            first_port_data <= '0;
            first_port_two <= 1'b0;
        end else if (ce && bus.up_ready) begin
            first_port_valid <= bus.up_valid; // R12 R13 R14
            if (bus.up_valid) begin
                first_port_data <= bus.up_data;
                first_port_two <= bus.up_two;
            end
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            second_port_valid <= 1'b0;
            second_port_data <= '0;
        end else if (ce && bus.lo_ready) begin
            second_port_valid <= bus.lo_valid & ~single_port; // R12 R13 R14
            if (bus.lo_valid) begin
                second_port_data <= bus.lo_data;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/csj_monitor.sv ***
// assertions on the link between the pipe end and the datapath end
`timescale 1ns/1ps
`default_nettype none
`include "csj_consts.svh"
module csj_monitor import csj_pkg::*; (
    input wire logic clk,
    input wire logic rstn,
    input wire csj_cfg_t cfg,
    input wire logic vblank,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire csj_pix_t in_a,
    input wire csj_pix_t in_b,
    input wire csj_pix_t in_alt,
    input wire logic in_b_en,
    input wire logic up_valid,
    input wire logic up_ready,
    input wire logic [2*`CSJ_PIX_W-1:0] up_data,
    input wire logic up_two,
    input wire logic lo_valid,
    input wire logic lo_ready,
    input wire csj_pix_t lo_data
);
    csj_cfg_t act;
    // settings swap only at blank, so the checker keeps its own applied copy
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            act <= '0;
        end else if (vblank) begin
            act <= cfg;
        end
    end
    wire logic take = in_valid && in_ready;
    wire logic jn = act.split && act.comp && act.joiner;
    wire logic sp = act.split && !act.joiner;
    // independent ports use the lower mux without the splitter
    wire logic lo_use = sp || (in_b_en && act.comp && !act.split && !act.joiner);
    wire csj_pix_t src = act.psr2 ? in_alt : in_a;
    wire csj_pix_t el = act.comp ? src >> act.left.drop : src;
    wire csj_pix_t er = act.comp ? in_b >> act.right.drop : in_b;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_up_hold_word: assert property (up_valid && !up_ready |=> up_valid && $stable(up_data) && $stable(up_two))
        else $error("upper word changed while stalled");
    a_lo_hold_word: assert property (lo_valid && !lo_ready |=> lo_valid && $stable(lo_data))
        else $error("lower word changed while stalled");
    a_up_word_path: assert property (take && !up_valid && !jn |=> up_valid && up_data == {30'h0, $past(el)})
        else $error("upper word wrong");
    a_join_word_pair: assert property (take && !up_valid && jn |=>
        up_valid && up_two && up_data == {$past(er), $past(el)})
        else $error("joined word wrong");
    a_lo_word_path: assert property (take && !lo_valid && lo_use |=> lo_valid && lo_data == $past(er))
        else $error("lower word wrong");
    a_two_only_join: assert property (up_valid && up_two |-> jn)
        else $error("two words outside joiner mode");
    a_lo_idle_unsplit: assert property (!act.split && !(take && in_b_en) && !lo_valid |=> !lo_valid)
        else $error("lower mux active without splitter");
    a_ready_has_room: assert property (!in_ready |-> up_valid || lo_valid)
        else $error("input refused while buffers empty");
endmodule
`default_nettype wire

// *** tb/tb_compression_split_join_path.sv ***
// self-checking bench joining the pipe end and the datapath end
`timescale 1ns/1ps
`default_nettype none
`include "csj_consts.svh"
module tb_compression_split_join_path import csj_pkg::*;;
    logic clk = 0, rstn = 0, prog = 0, fec_en = 0, frame_vblank = 0, px_valid = 0, px_eol = 0, psr2 = 0;
    logic big_joiner = 0, px_b_en = 0, ram_over;
    logic fp_ready = 1, sp_ready = 1, lo_on = 0, px_ready, fp_valid, fp_two, sp_valid, cfg_err;
    csj_use_t use_case = CSJ_UC_PLAIN;
    logic [3:0] slices = 4'h1;
    logic [`CSJ_WID_W-1:0] alw = 14'h0100;
    logic [12:0] frame_h = 13'h0060, slice_h = 13'h0020;
    logic [5:0] bpp = 6'h0C;
    logic [31:0] pclk = 32'h00030D40, core = 32'h000F4240, link = 32'h000C5C10;
    logic [2:0] lanes = 3'h4;
    csj_pix_t px_a = '0, px_b = '0, px_alt = '0, sp_data;
    logic [59:0] fp_data;
    logic [7:0] max_bpp;
    csj_mode_t mode;
    int bad_count = 0, check_count = 0, seed = 60593, cur = 0;
    logic [60:0] qu[$];
    csj_pix_t ql[$];
    csj_use_t uses[8] = '{CSJ_UC_PLAIN, CSJ_UC_ODD, CSJ_UC_SEG_RAW, CSJ_UC_SEG_DSC, CSJ_UC_DUAL_RAW,
        CSJ_UC_DUAL_DSC, CSJ_UC_EVEN, CSJ_UC_INDEP};
    int cls[8] = '{0, 1, 2, 3, 2, 3, 4, 1};
    logic [2:0] sw[8] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h4, 3'h6, 3'h7, 3'h2};
    logic [3:0] nsl[8] = '{4'h1, 4'h3, 4'h2, 4'h2, 4'h2, 4'h2, 4'h4, 4'h1};
    initial begin
        forever #2 clk = ~clk;
    end
    csj_if u_csj_if (.clk(clk), .rstn(rstn));
    csj_src u_csj_src (.clk(clk), .rstn(rstn), .ce(1'b1), .bus(u_csj_if.host), .prog(prog), .use_case(use_case),
        .slices(slices), .active_line_width(alw), .frame_h(frame_h), .slice_h(slice_h), .bpp_req(bpp),
        .psr2(psr2), .pclk_khz(pclk), .core_clk_khz(core), .port_link_clock_khz(link), .lanes(lanes),
        .fec_en(fec_en), .big_joiner(big_joiner), .frame_vblank(frame_vblank), .px_valid(px_valid),
        .px_ready(px_ready), .px_a(px_a), .px_b(px_b), .px_alt(px_alt), .px_b_en(px_b_en), .px_eol(px_eol),
        .first_port_valid(fp_valid), .first_port_ready(fp_ready), .first_port_data(fp_data),
        .first_port_two(fp_two), .second_port_valid(sp_valid), .second_port_ready(sp_ready),
        .second_port_data(sp_data), .cfg_err(cfg_err), .max_bpp(max_bpp));
    csj_path u_csj_path (.clk(clk), .rstn(rstn), .ce(1'b1), .bus(u_csj_if.dev), .mode(mode), .ram_over(ram_over));
    csj_monitor u_csj_monitor (.clk(clk), .rstn(rstn), .cfg(u_csj_if.cfg), .vblank(u_csj_if.vblank),
        .in_valid(u_csj_if.in_valid), .in_ready(u_csj_if.in_ready), .in_a(u_csj_if.in_a), .in_b(u_csj_if.in_b),
        .in_alt(u_csj_if.in_alt), .in_b_en(u_csj_if.in_b_en), .up_valid(u_csj_if.up_valid),
        .up_ready(u_csj_if.up_ready),
        .up_data(u_csj_if.up_data), .up_two(u_csj_if.up_two), .lo_valid(u_csj_if.lo_valid),
        .lo_ready(u_csj_if.lo_ready), .lo_data(u_csj_if.lo_data));
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // result watcher: oldest note against each delivered word
    always @(posedge clk) begin
        if (rstn && fp_valid && fp_ready) begin
            check("first port count", qu.size() > 0, 1);
            if (qu.size() > 0) begin
                check("first port", {fp_two, fp_data}, qu.pop_front());
            end
        end
        if (rstn && sp_valid && sp_ready) begin
            check("second port count", lo_on && ql.size() > 0, 1);
            if (lo_on && ql.size() > 0) begin
                check("second port", sp_data, ql.pop_front());
            end
        end
    end
    task automatic probe(input logic err, input logic [7:0] mx);
        @(negedge clk);
        prog = 1;
        @(negedge clk);
        prog = 0;
        check("cfg error", cfg_err, err);
        if (!err) begin
            check("max bpp", max_bpp, mx);
        end
    endtask
    task automatic set_mode(input int k);
        csj_mode_t old;
        old = mode;
        use_case = uses[k];
        slices = nsl[k];
        bpp = 6'(8 + 2 * k);
        cur = cls[k];
        // alternate source on bypass, split-compress and joiner; only lane a reads it
        psr2 = k % 3 == 0;
        probe(0, 8'h81);
        check("mode held", mode, old);
        check("switches", {u_csj_if.cfg.split, u_csj_if.cfg.comp, u_csj_if.cfg.joiner}, sw[k]);
        if (cur >= 3) begin
            check("slice width", u_csj_if.cfg.right.slice_w, alw / slices);
            check("picture width", u_csj_if.cfg.left.pic_w, alw / 2);
        end
        @(negedge clk);
        frame_vblank = 1;
        @(negedge clk);
        frame_vblank = 0;
        repeat (3) @(negedge clk);
        check("mode", mode, 5'h01 << cur);
        lo_on = cur == 2 || cur == 3 || uses[k] == CSJ_UC_INDEP;
    endtask
    task automatic send(input int n);
        csj_pix_t a, b, ea, eb;
        logic cmp;
        cmp = cur == 1 || cur >= 3;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            a = 30'($random(seed));
            b = 30'($random(seed));
            {px_a, px_b, px_alt, px_eol, px_valid, px_b_en} = {a, b, ~a, i % 8 == 7, 1'b1, 1'($random(seed))};
            {fp_ready, sp_ready} = 2'($random(seed));
            #1;
            // the stalled readers fill the buffers in use, so refusal is exercised here
            for (int t = 0; px_ready !== 1'b1 && t < 50; t++) begin
                @(negedge clk);
                {fp_ready, sp_ready} = 2'($random(seed));
                #1;
            end
            check("accepted", px_ready, 1);
            ea = psr2 ? ~a : a;
            ea = cmp ? ea >> (30 - bpp) : ea;
            eb = cmp ? b >> (30 - bpp) : b;
            qu.push_back(cur == 4 ? {1'b1, eb, ea} : {31'h0, ea});
            // a second pipe only offers a back word when its lane is flagged
            if (lo_on && (cur != 1 || px_b_en)) begin
                ql.push_back(eb);
            end
        end
        @(negedge clk);
        {px_valid, fp_ready, sp_ready} = 3'h3;
        for (int t = 0; qu.size() + ql.size() > 0 && t < 50; t++) begin
            @(negedge clk);
        end
        check("drained", qu.size() + ql.size(), 0);
        check("ram over", ram_over, 1'b0);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rstn = 1;
        for (int k = 0; k < 8; k++) begin
            set_mode(k);
            send(40);
        end
        frame_h = 13'h0064;
        probe(1, 8'h00);
        frame_h = 13'h0060;
        core = 32'h000186A0;
        probe(1, 8'h00);
        core = 32'h000F4240;
        fec_en = 1;
        probe(0, 8'h7E);
        big_joiner = 1;
        probe(0, 8'h74);
        alw = 14'h1000;
        probe(0, 8'h1E);
        conclude();
    end
    initial begin
        #50000;
        bad_count++;
        conclude();
    end
endmodule
`default_nettype wire
